// ===== serial_eeprom_pkg.sv
// constants, command codes and carrier types of the serial eeprom protect logic
package serial_eeprom_pkg;

   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int NS_PER_US = 1000;

   // ------------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_PROTECTION_REG_WRITE = 8'h01;
   localparam logic [7:0] OP_LATCH_SET_CMD = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] OP_PAGE_WIPE = 8'h42;
   localparam logic [7:0] OP_SECTOR_WIPE = 8'hD8;
   localparam logic [7:0] OP_CHIP_WIPE = 8'hC7;
   localparam logic [7:0] OP_SIGNATURE_READ_WAKE = 8'hAB;
   localparam logic [7:0] OP_DEEP_SLEEP_ENTRY = 8'hB9;

   // ------------------------------------------------------------------
   // frame lengths in serial clocks
   // ------------------------------------------------------------------
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_OP_DATA = 6'h10;
   localparam logic [5:0] BITS_OP_ADDR = 6'h18;
   localparam logic [5:0] BITS_SIG_LAST = 6'h1F;
   localparam logic [5:0] BITS_MAX = 6'h3F;
   localparam logic [5:0] BITS_OP_LAST = 6'h07;

   // ------------------------------------------------------------------
   // status byte layout
   // ------------------------------------------------------------------
   localparam int ST_PIN_PROTECT_ARM = 7;
   localparam int ST_BLOCK_PROTECT_HIGH = 3;
   localparam int ST_BLOCK_PROTECT_LOW = 2;
   localparam int ST_WRITE_ENABLE_LATCH = 1;
   localparam int ST_WRITE_IN_PROGRESS = 0;
   localparam logic [1:0] BP_RESET = 2'h0;
   localparam logic PIN_ARM_RESET = 1'b0;

   // ------------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------------
   localparam logic [15:0] PROT_QUARTER_BASE = 16'hC000;
   localparam logic [15:0] PROT_HALF_BASE = 16'h8000;
   localparam logic [15:0] PAGE_BASE_MASK = 16'hFF80;
   localparam logic [15:0] SECTOR_BASE_MASK = 16'hC000;
   localparam logic [15:0] ARRAY_BASE = 16'h0000;

   // ------------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      WIPE_PAGE,
      WIPE_SECTOR,
      WIPE_CHIP,
      WIPE_STATUS
   } wipe_kind_t;

   typedef struct packed {
      logic active;
      wipe_kind_t kind;
      logic [15:0] base;
   } wipe_req_t;

   typedef struct packed {
      logic [5:0] bits;
      logic [7:0] opcode;
      logic [15:0] tail;
   } frame_t;

endpackage : serial_eeprom_pkg

// ===== serial_eeprom_protect.sv
// command, protection, erase and power-down logic of the serial eeprom
//
// Function
// [R1] block-protect pair selects protected upper range
// [R2] status write changes only nonvolatile bits
// [R3] pin protection needs pin low, arm set
// [R4] pin protection blocks only status writes
// [R5] cleared latch blocks every write
// [R6] latch clears when a write completes
// [R7] only a correctly counted frame end writes
// [R8] commands ignored while internal write runs
// [R9] reset leaves standby, latch clear, output off
// [R10] erase needs latch set beforehand
// [R11] page erase wipes addressed page
// [R12] page erase only on exact framing
// [R13] protected page erase aborts
// [R14] sector erase wipes addressed quarter
// [R15] sector erase only on exact framing
// [R16] protected sector erase aborts
// [R17] chip erase only after eight bits
// [R18] chip erase ignored if any block protection
// [R19] sleep only after exactly eight bits
// [R20] sleep ignores all but signature read
// [R21] signature follows opcode and dummy address
// [R22] signature repeats while clocks continue
// [R23] signature refused while write in progress
// [R24] wake opcode alone still leaves sleep
// [R25] erase opcode decode
// [R26] signature, sleep, status write decode
// [R27] status byte bit layout
// [R28] status write is opcode plus one byte
// [R29] progress bit spans cycle, clears with latch
`timescale 1ns/1ps

module serial_eeprom_protect
   import serial_eeprom_pkg::*;
#(
   parameter int PAGE_WIPE_US = 1000,
   parameter int SECTOR_WIPE_US = 2000,
   parameter int CHIP_WIPE_US = 2000,
   parameter int STATUS_WRITE_US = 1000,
   parameter int SLEEP_SETTLE_DELAY_US = 10,
   parameter int WAKE_DELAY_US = 10,
   parameter logic [7:0] SIGNATURE = 8'h5A
) (
   // system clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial link pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   output logic so_out,
   output logic so_oe,
   // state seen by the array controller
   output logic [7:0] status_byte,
   output wipe_req_t wipe_req,
   output logic asleep
);

   // ------------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------------
   localparam int PAGE_CYC = PAGE_WIPE_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int SECTOR_CYC = SECTOR_WIPE_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int CHIP_CYC = CHIP_WIPE_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int STATUS_CYC = STATUS_WRITE_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int SETTLE_CYC =
      SLEEP_SETTLE_DELAY_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int WAKE_CYC = WAKE_DELAY_US * NS_PER_US / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      STANDBY,
      BUSY,
      SETTLE,
      SLEEP,
      WAKE
   } mode_t;

   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   logic rst_meta;
   logic rst_ok;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_ok <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_ok <= rst_meta;
      end
   end

   // ------------------------------------------------------------------
   // link side: bit capture on the serial clock
   // ------------------------------------------------------------------
   // the counters are not cleared by deselect, so they hold the last
   // frame steady while the system side reads them after chip select
   // rises; the first edge of the next frame restarts them
   logic link_clr;
   logic fresh;
   logic [5:0] bit_cnt;
   logic [5:0] next_bit_cnt;
   logic [7:0] opcode;
   logic [15:0] tail;
   logic busy_meta;
   logic busy_link;
   logic write_in_progress;

   assign link_clr = cs_n | ~rst_ok;

   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_comb begin
      if (fresh) begin
         next_bit_cnt = 6'h01;
      end else if (opcode == OP_SIGNATURE_READ_WAKE &&
                   bit_cnt == BITS_SIG_LAST) begin
         next_bit_cnt = BITS_OP_ADDR; // [R22]
      end else if (bit_cnt == BITS_MAX) begin
         next_bit_cnt = BITS_MAX;
      end else begin
         next_bit_cnt = 6'(bit_cnt + 6'h01);
      end
   end

   always_ff @(posedge sck or negedge rst_ok) begin
      if (!rst_ok) begin
         bit_cnt <= 6'h00;
         tail <= 16'h0000;
      end else begin
         bit_cnt <= next_bit_cnt;
         tail <= {tail[14:0], si};
      end
   end

   always_ff @(posedge sck or negedge rst_ok) begin
      if (!rst_ok) begin
         opcode <= 8'h00;
      end else if (fresh) begin
         opcode <= {7'h00, si};
      end else if (bit_cnt < BITS_OPCODE) begin
         opcode <= {opcode[6:0], si};
      end
   end

   // progress flag brought over to the link clock for the signature gate
   always_ff @(posedge sck or negedge rst_ok) begin
      if (!rst_ok) begin
         busy_meta <= 1'b0;
         busy_link <= 1'b0;
      end else begin
         busy_meta <= write_in_progress;
         busy_link <= busy_meta;
      end
   end

   // ------------------------------------------------------------------
   // link side: signature out on the falling edge
   // ------------------------------------------------------------------
   logic sig_phase;

   assign sig_phase = ~fresh && opcode == OP_SIGNATURE_READ_WAKE &&
                      bit_cnt >= BITS_OP_ADDR && ~busy_link; // [R21] [R23]

   always_ff @(negedge sck or posedge link_clr) begin
      if (link_clr) begin
         so_oe <= 1'b0; // [R9]
         so_out <= 1'b0;
      end else begin
         so_oe <= sig_phase;
         so_out <= sig_phase & SIGNATURE[~bit_cnt[2:0]]; // [R22]
      end
   end

   // ------------------------------------------------------------------
   // system side: pin synchronisers and frame end
   // ------------------------------------------------------------------
   logic cs_meta;
   logic cs_sync;
   logic cs_last;
   logic wp_meta;
   logic wp_sync;
   logic frame_end;
   frame_t frame;

   always_ff @(posedge clk or negedge rst_ok) begin
      if (!rst_ok) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_last <= 1'b1;
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
      end else begin
         cs_meta <= cs_n;
         cs_sync <= cs_meta;
         cs_last <= cs_sync;
         wp_meta <= wp_n;
         wp_sync <= wp_meta;
      end
   end

   // link registers are quiet while deselected, so they are read here
   // only once the raised chip select has passed the synchroniser
   assign frame_end = cs_sync & ~cs_last; // [R7]
   assign frame.bits = bit_cnt;
   assign frame.opcode = opcode;
   assign frame.tail = tail;

   // ------------------------------------------------------------------
   // protection decode
   // ------------------------------------------------------------------
   logic [1:0] block_protect;
   logic pin_protect_arm;
   logic write_enable_latch;
   logic hw_protect;
   logic addr_protected;
   logic [15:0] addr;

   assign addr = frame.tail;
   assign hw_protect = ~wp_sync & pin_protect_arm; // [R3]

   always_comb begin
      case (block_protect) // [R1]
         2'h0: addr_protected = 1'b0;
         2'h1: addr_protected = addr >= PROT_QUARTER_BASE;
         2'h2: addr_protected = addr >= PROT_HALF_BASE;
         default: addr_protected = 1'b1;
      endcase
   end

   // ------------------------------------------------------------------
   // command decode at frame end
   // ------------------------------------------------------------------
   logic op_len8;
   logic op_len16;
   logic op_len24;
   logic go_page;
   logic go_sector;
   logic go_chip;
   logic go_status;
   logic go_sleep;
   logic go_wake;

   assign op_len8 = frame.bits == BITS_OPCODE;
   assign op_len16 = frame.bits == BITS_OP_DATA;
   assign op_len24 = frame.bits == BITS_OP_ADDR;

   assign go_page = frame.opcode == OP_PAGE_WIPE && op_len24 && // [R25] [R12]
                    write_enable_latch && ~addr_protected; // [R10] [R13]
   assign go_sector = frame.opcode == OP_SECTOR_WIPE && op_len24 && // [R15]
                      write_enable_latch && ~addr_protected; // [R16]
   assign go_chip = frame.opcode == OP_CHIP_WIPE && op_len8 && // [R17]
                    write_enable_latch && block_protect == 2'h0; // [R18]
   assign go_status = frame.opcode == OP_PROTECTION_REG_WRITE && // [R26]
                      op_len16 && // [R28]
                      write_enable_latch && ~hw_protect; // [R4] [R5]
   assign go_sleep = frame.opcode == OP_DEEP_SLEEP_ENTRY && op_len8; // [R19]
   assign go_wake = frame.opcode == OP_SIGNATURE_READ_WAKE &&
                    frame.bits >= BITS_OPCODE; // [R24]

   // ------------------------------------------------------------------
   // mode sequencer and self-timed cycle
   // ------------------------------------------------------------------
   mode_t mode;
   logic [31:0] timer;
   logic [7:0] pending_status;
   logic cycle_done;

   assign cycle_done = timer == 32'h0000_0000;

   always_ff @(posedge clk or negedge rst_ok) begin
      if (!rst_ok) begin
         mode <= STANDBY; // [R9]
         timer <= 32'h0000_0000;
      end else begin
         case (mode)
            STANDBY: begin
               if (frame_end) begin
                  if (go_page) begin
                     mode <= BUSY;
                     timer <= 32'(PAGE_CYC);
                  end else if (go_sector) begin
                     mode <= BUSY;
                     timer <= 32'(SECTOR_CYC);
                  end else if (go_chip) begin
                     mode <= BUSY;
                     timer <= 32'(CHIP_CYC);
                  end else if (go_status) begin
                     mode <= BUSY;
                     timer <= 32'(STATUS_CYC);
                  end else if (go_sleep) begin
                     mode <= SETTLE;
                     timer <= 32'(SETTLE_CYC);
                  end
               end
            end
            // frames during the cycle are dropped, the cycle runs on
            BUSY, SETTLE, WAKE: begin // [R8]
               if (cycle_done) begin
                  mode <= mode == SETTLE ? SLEEP : STANDBY;
               end else begin
                  timer <= 32'(timer - 32'h0000_0001);
               end
            end
            SLEEP: begin
               if (frame_end && go_wake) begin // [R20]
                  mode <= WAKE;
                  timer <= 32'(WAKE_CYC);
               end
            end
            default: begin
               mode <= STANDBY;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_ok) begin
      if (!rst_ok) begin
         wipe_req <= '{active: 1'b0, kind: WIPE_PAGE, base: ARRAY_BASE};
         pending_status <= 8'h00;
      end else if (mode == STANDBY && frame_end) begin
         if (go_page) begin
            wipe_req <= '{1'b1, WIPE_PAGE, addr & PAGE_BASE_MASK}; // [R11]
         end else if (go_sector) begin
            wipe_req <= '{1'b1, WIPE_SECTOR,
                          addr & SECTOR_BASE_MASK}; // [R14]
         end else if (go_chip) begin
            wipe_req <= '{1'b1, WIPE_CHIP, ARRAY_BASE};
         end else if (go_status) begin
            wipe_req <= '{1'b1, WIPE_STATUS, ARRAY_BASE};
            pending_status <= frame.tail[7:0];
         end
      end else if (mode == BUSY && cycle_done) begin
         wipe_req.active <= 1'b0;
      end
   end

   assign write_in_progress = mode == BUSY; // [R29]

   // ------------------------------------------------------------------
   // status bits
   // ------------------------------------------------------------------
   // no backing store for the nonvolatile bits: they come up unprotected
   always_ff @(posedge clk or negedge rst_ok) begin
      if (!rst_ok) begin
         block_protect <= BP_RESET;
         pin_protect_arm <= PIN_ARM_RESET;
      end else if (mode == BUSY && cycle_done &&
                   wipe_req.kind == WIPE_STATUS) begin
         block_protect <= {pending_status[ST_BLOCK_PROTECT_HIGH],
                           pending_status[ST_BLOCK_PROTECT_LOW]}; // [R2]
         pin_protect_arm <= pending_status[ST_PIN_PROTECT_ARM];
      end
   end

   always_ff @(posedge clk or negedge rst_ok) begin
      if (!rst_ok) begin
         write_enable_latch <= 1'b0; // [R9]
      end else if (mode == BUSY && cycle_done) begin
         write_enable_latch <= 1'b0; // [R6] [R29]
      end else if (mode == STANDBY && frame_end && op_len8) begin
         if (frame.opcode == OP_LATCH_SET_CMD) begin
            write_enable_latch <= 1'b1;
         end else if (frame.opcode == OP_LATCH_CLEAR_CMD) begin
            write_enable_latch <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_ok) begin
      if (!rst_ok) begin
         status_byte <= 8'h00;
         asleep <= 1'b0;
      end else begin
         status_byte <= 8'h00;
         status_byte[ST_PIN_PROTECT_ARM] <= pin_protect_arm; // [R27]
         status_byte[ST_BLOCK_PROTECT_HIGH] <= block_protect[1];
         status_byte[ST_BLOCK_PROTECT_LOW] <= block_protect[0];
         status_byte[ST_WRITE_ENABLE_LATCH] <= write_enable_latch;
         status_byte[ST_WRITE_IN_PROGRESS] <= write_in_progress;
         asleep <= mode == SETTLE || mode == SLEEP;
      end
   end

endmodule : serial_eeprom_protect

// ===== serial_eeprom_protect_props.sv
// port checks of the serial eeprom protect logic
`timescale 1ns/1ps
module serial_eeprom_protect_props
   import serial_eeprom_pkg::*;
(
   // clock, reset and pins
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   input wire logic so_out,
   input wire logic so_oe,
   // state outputs
   input wire logic [7:0] status_byte,
   input wire wipe_req_t wipe_req,
   input wire logic asleep
);
   // ----
   // helpers
   // ----
   logic act_q;
   wire logic start = wipe_req.active && !act_q;
   wire logic [1:0] bp = status_byte[3:2];
   wire logic [15:0] base = wipe_req.base;
   wire wipe_kind_t kind = wipe_req.kind;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_q <= 1'b0;
      end else begin
         act_q <= wipe_req.active;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ----
   // properties
   // ----
   property p_oe_off; cs_n |-> !so_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("so on, deselected");
   property p_wip; start |-> ##[0:2] status_byte[0]; endproperty
   a_wip: assert property (p_wip)
      else $error("progress bit missing");
   property p_hold; start |=> wipe_req.active [*8]; endproperty
   a_hold: assert property (p_hold)
      else $error("cycle cut short");
   property p_frame; start |-> cs_n && $past(cs_n, 2); endproperty
   a_frame: assert property (p_frame)
      else $error("cycle inside frame");
   property p_latch; start |-> status_byte[1]; endproperty
   a_latch: assert property (p_latch)
      else $error("cycle without latch");
   property p_page;
      start && kind == WIPE_PAGE |-> base[6:0] == 7'h00;
   endproperty
   a_page: assert property (p_page)
      else $error("page base off");
   property p_sect;
      start && kind == WIPE_SECTOR |-> base[13:0] == 14'h0000;
   endproperty
   a_sect: assert property (p_sect)
      else $error("sector base off");
   property p_guard;
      start && kind inside {WIPE_PAGE, WIPE_SECTOR} |-> bp == 2'h0
         || (bp == 2'h1 && base < PROT_QUARTER_BASE)
         || (bp == 2'h2 && base < PROT_HALF_BASE);
   endproperty
   a_guard: assert property (p_guard)
      else $error("protected wipe");
   property p_chip; start && kind == WIPE_CHIP |-> bp == 2'h0; endproperty
   a_chip: assert property (p_chip)
      else $error("chip wipe protected");
   property p_done;
      $fell(wipe_req.active) |-> ##[0:2] status_byte[1:0] == 2'h0;
   endproperty
   a_done: assert property (p_done)
      else $error("latch left set");
   property p_pin;
      start && kind == WIPE_STATUS |-> wp_n || !status_byte[7];
   endproperty
   a_pin: assert property (p_pin)
      else $error("status write pinned");
   property p_sig; so_oe |-> !status_byte[0]; endproperty
   a_sig: assert property (p_sig)
      else $error("signature while busy");

   c_page: cover property (start && kind == WIPE_PAGE);
   c_sleep: cover property ($rose(asleep));
   c_sig: cover property ($rose(so_oe));
endmodule : serial_eeprom_protect_props

bind serial_eeprom_protect serial_eeprom_protect_props u_props (
   .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
   .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
   .status_byte(status_byte), .wipe_req(wipe_req), .asleep(asleep)
);

// ===== spi_host_model.sv
// spi host model that frames commands on the link
`timescale 1ns/1ps
module spi_host
(
   // link pins
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so_out,
   input wire logic so_oe
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // mode 0, msb first; sck stands low outside frames
   task automatic xfer(input logic [39:0] d, input int n,
                       output logic [15:0] rx);
      int i;
      rx = 16'hxxxx;
      cs_n = 1'b0;
      #40;
      for (i = 0; i < n; i++) begin
         si = d[39 - i];
         #40;
         sck = 1'b1;
         // an undriven output reads as unknown
         if (i >= 24 && i < 40) rx[39 - i] = so_oe ? so_out : 1'bx;
         #80;
         sck = 1'b0;
         #40;
      end
      cs_n = 1'b1;
      si = ~si;
   endtask : xfer
endmodule : spi_host

// ===== serial_eeprom_protect_tb.sv
// self-checking bench of the serial eeprom protect logic
`timescale 1ns/1ps
module serial_eeprom_protect_tb;
   import serial_eeprom_pkg::*;
   // signature value is arbitrary
   localparam logic [7:0] SIG = 8'h5A;
   logic clk;
   logic rst_n;
   logic wp_n;
   logic sck;
   logic cs_n;
   logic si;
   logic so_out;
   logic so_oe;
   logic asleep;
   logic [7:0] status_byte;
   wipe_req_t wipe_req;
   logic [15:0] rx;
   int errors;
   int checked;

   // cycle times stretched past a full signature frame; the release
   // delay keeps its default so commands inside it can be probed
   serial_eeprom_protect #(
      .PAGE_WIPE_US(8), .SECTOR_WIPE_US(8), .CHIP_WIPE_US(8),
      .STATUS_WRITE_US(8), .SLEEP_SETTLE_DELAY_US(2), .SIGNATURE(SIG)
   ) u_dut (
      .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
      .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
      .status_byte(status_byte), .wipe_req(wipe_req), .asleep(asleep)
   );
   spi_host u_host (
      .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----
   // tasks
   // ----
   task automatic conclude();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic check(input string nm, input logic [18:0] seen,
                        input logic [18:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic pause(input int n);
      repeat (n) @(negedge clk);
   endtask : pause

   // frame end, then cs_n high well beyond the 4 clk gap
   task automatic send(input logic [7:0] op, input logic [15:0] t,
                       input int n);
      u_host.xfer({op, t, 16'h0000}, n, rx);
      pause(8);
   endtask : send

   // latch set as a frame of its own before each write
   task automatic er(input logic [7:0] op, input logic [15:0] t,
                     input int n);
      send(OP_LATCH_SET_CMD, 16'h0000, 8);
      send(op, t, n);
   endtask : er

   task automatic wr(input logic [7:0] d);
      er(OP_PROTECTION_REG_WRITE, {d, 8'h00}, 16);
   endtask : wr

   task automatic idle();
      int i;
      for (i = 0; i < 500 && wipe_req.active !== 1'b0; i++) pause(1);
      if (i == 500) begin
         errors++;
         conclude();
      end
      pause(4);
   endtask : idle

   // ----
   // sequence
   // ----
   initial begin
      errors = 0;
      checked = 0;
      rst_n = 1'b0;
      wp_n = 1'b1;
      pause(12);
      rst_n = 1'b1;
      pause(6);
      check("status", status_byte, 8'h00);
      check("so_oe", so_oe, 1'b0);
      check("asleep", asleep, 1'b0);
      send(OP_PROTECTION_REG_WRITE, 16'hFF00, 16);
      check("locked", status_byte, 8'h00);
      send(OP_LATCH_SET_CMD, 16'h0000, 8);
      check("latch", status_byte, 8'h02);
      send(OP_LATCH_CLEAR_CMD, 16'h0000, 8);
      check("unlatch", status_byte, 8'h00);
      wr(8'hFF);
      check("busy", status_byte[1:0], 2'h3);
      idle();
      check("written", status_byte, 8'h8C);
      wp_n = 1'b0;
      wr(8'h00);
      check("pinned", status_byte[7:2], 6'h23);
      check("no cycle", wipe_req.active, 1'b0);
      wp_n = 1'b1;
      wr(8'h04);
      idle();
      check("bp01", status_byte, 8'h04);
      er(OP_CHIP_WIPE, 16'h0000, 8);
      check("chip bp", wipe_req.active, 1'b0);
      er(OP_PAGE_WIPE, 16'hC123, 24);
      check("page prot", wipe_req.active, 1'b0);
      er(OP_PAGE_WIPE, 16'h8123, 23);
      check("page short", wipe_req.active, 1'b0);
      er(OP_PAGE_WIPE, 16'h8123, 24);
      check("page", wipe_req, {1'b1, WIPE_PAGE, 16'h8100});
      send(OP_LATCH_CLEAR_CMD, 16'h0000, 8);
      check("busy latch", status_byte[1:0], 2'h3);
      send(OP_SIGNATURE_READ_WAKE, 16'h0000, 32);
      check("sig busy", rx, 16'hxxxx);
      idle();
      check("page done", status_byte, 8'h04);
      wp_n = 1'b0;
      wr(8'h08);
      idle();
      check("arm off", status_byte, 8'h08);
      er(OP_SECTOR_WIPE, 16'h9000, 24);
      check("sect prot", wipe_req.active, 1'b0);
      er(OP_SECTOR_WIPE, 16'h5678, 23);
      check("sect short", wipe_req.active, 1'b0);
      er(OP_SECTOR_WIPE, 16'h5678, 24);
      check("sector", wipe_req, {1'b1, WIPE_SECTOR, 16'h4000});
      idle();
      wr(8'h00);
      idle();
      er(OP_CHIP_WIPE, 16'h0000, 9);
      check("chip long", wipe_req.active, 1'b0);
      er(OP_CHIP_WIPE, 16'h0000, 8);
      check("chip", wipe_req, {1'b1, WIPE_CHIP, 16'h0000});
      idle();
      send(OP_PAGE_WIPE, 16'h1234, 24);
      check("page nolatch", wipe_req.active, 1'b0);
      send(OP_SIGNATURE_READ_WAKE, 16'h0000, 40);
      check("sig", rx, {SIG, SIG});
      send(OP_DEEP_SLEEP_ENTRY, 16'h0000, 9);
      check("no sleep", asleep, 1'b0);
      send(OP_DEEP_SLEEP_ENTRY, 16'h0000, 8);
      check("sleep", asleep, 1'b1);
      pause(100);
      send(OP_LATCH_SET_CMD, 16'h0000, 8);
      check("deaf", status_byte, 8'h00);
      send(OP_SIGNATURE_READ_WAKE, 16'h0000, 40);
      check("sleep sig", rx, {SIG, SIG});
      pause(100);
      check("woken", asleep, 1'b0);
      send(OP_LATCH_SET_CMD, 16'h0000, 8);
      check("release delay", status_byte, 8'h00);
      pause(300);
      send(OP_DEEP_SLEEP_ENTRY, 16'h0000, 8);
      pause(100);
      send(OP_SIGNATURE_READ_WAKE, 16'h0000, 8);
      pause(100);
      check("wake short", asleep, 1'b0);
      conclude();
   end
endmodule : serial_eeprom_protect_tb
